// ### io_map_pkg.sv
// Register map, reset values and timing constants of the serial I/O register bank
//
// Summary of operation
// (R1) 0-20 mA setpoint in microamps, max 20480
// (R2) 4-20 mA setpoint in per-mille, max 1000
// (R3) Voltage setpoint in millivolts, max 10240
// (R4) Outputs take safe pattern after reset, timeout
// (R5) Three split 32-bit packet counters, read/write
// (R6) Erroneous packets counted apart from all received
// (R7) Read-only identity register at offset zero
// (R8) Protocol mode register selects framing
// (R9) Wait reply delay milliseconds before each reply
// (R10) Watchdog timeout applies defaults; zero disables
// (R11) Mode zero is RTU, one is ASCII
// (R12) All data held as 16-bit registers
// (R13) Low word bits 15:0, high word 31:16
// (R14) Writes to read-only registers change nothing
package io_map_pkg;

   // Register address width and data width
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;

   // Register offsets
   localparam logic [15:0] OFS_IDENTITY = 16'h0000;
   localparam logic [15:0] OFS_NODE_ADDR = 16'h0001;
   localparam logic [15:0] OFS_LINE_SPEED = 16'h0002;
   localparam logic [15:0] OFS_FRAME_FORMAT = 16'h0003;
   localparam logic [15:0] OFS_PARITY = 16'h0004;
   localparam logic [15:0] OFS_REPLY_DELAY = 16'h0005;
   localparam logic [15:0] OFS_PROTOCOL_MODE = 16'h0006;
   localparam logic [15:0] OFS_LINK_TIMEOUT = 16'h0008;
   localparam logic [15:0] OFS_SAFE_PATTERN = 16'h000c;
   localparam logic [15:0] OFS_RX_LOW = 16'h0020;
   localparam logic [15:0] OFS_RX_HIGH = 16'h0021;
   localparam logic [15:0] OFS_BAD_LOW = 16'h0022;
   localparam logic [15:0] OFS_BAD_HIGH = 16'h0023;
   localparam logic [15:0] OFS_TX_LOW = 16'h0024;
   localparam logic [15:0] OFS_TX_HIGH = 16'h0025;
   localparam logic [15:0] OFS_INPUTS = 16'h0032;
   localparam logic [15:0] OFS_OUTPUTS = 16'h0033;
   localparam logic [15:0] OFS_CURRENT = 16'h0034;
   localparam logic [15:0] OFS_VOLTAGE = 16'h0035;

   // Reset values: 19200 baud, 8 data bits with 1 stop bit, no parity, RTU
   localparam logic [15:0] RST_LINE_SPEED = 16'h0003;
   localparam logic [15:0] RST_FRAME_FORMAT = 16'h0108;
   localparam logic [15:0] RST_PARITY = 16'h0000;
   localparam logic [15:0] RST_REPLY_DELAY = 16'h0000;
   localparam logic [15:0] RST_PROTOCOL_MODE = 16'h0000;
   localparam logic [15:0] RST_LINK_TIMEOUT = 16'h0000;
   localparam logic [15:0] RST_SAFE_PATTERN = 16'h0000;
   localparam logic [15:0] RST_SETPOINT = 16'h0000;

   // Setpoint limits
   localparam logic [15:0] CURRENT_MAX_UA = 16'h5000;
   localparam logic [15:0] CURRENT_MAX_PERMILLE = 16'h03e8;
   localparam logic [15:0] VOLTAGE_MAX_MV = 16'h2800;

   // Millisecond time base
   localparam int unsigned CLOCK_HZ = 125_000_000;
   localparam int unsigned MS_TIME_MS = 1;
   localparam int unsigned MS_CYCLES = CLOCK_HZ / 1000 * MS_TIME_MS;

   // Reply sequencing states
   typedef enum logic [0:0] {
      REPLY_IDLE = 1'b0,
      REPLY_WAIT = 1'b1
   } reply_state_type;

endpackage

// ### ms_timer.sv
// One-shot countdown of whole milliseconds, used for reply delay and watchdog
`timescale 1ns/1ns
`default_nettype none
module ms_timer (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic start,
   input wire logic stop,
   input wire logic msTick,
   input wire logic [15:0] limit,
   // Status
   output logic expired,
   output logic busy
);

   logic [15:0] count_q; // Milliseconds still to go
   logic busy_q; // Countdown running

   // Load on start, count ticks, stop itself once zero is seen
   always_ff @(posedge clock) begin
      if (rst || stop) begin
         busy_q <= 1'b0;
         count_q <= 16'h0000;
      end else if (start) begin
         busy_q <= 1'b1;
         count_q <= limit;
      end else if (busy_q) begin
         if (count_q == 16'h0000) begin
            busy_q <= 1'b0;
         end else if (msTick) begin
            count_q <= count_q - 16'h0001;
         end
      end
   end

   // Expiry lasts the single cycle in which zero is reached
   assign expired = busy_q && (count_q == 16'h0000);
   assign busy = busy_q;

endmodule
`default_nettype wire

// ### stat_counter.sv
// 32-bit packet statistics counter reachable as two 16-bit words
`timescale 1ns/1ns
`default_nettype none
module stat_counter (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Event and word writes
   input wire logic inc,
   input wire logic wrLow,
   input wire logic wrHigh,
   input wire logic [15:0] wdata,
   // Count
   output logic [31:0] value
);

   logic [31:0] count_q; // Running count
   logic [31:0] base; // Count with any written word merged in

   // (R13) word split of writes
   always_comb begin
      base = count_q;
      if (wrLow) begin
         base[15:0] = wdata;
      end
      if (wrHigh) begin
         base[31:16] = wdata;
      end
   end

   // An event in the same cycle as a write still counts on top of it
   always_ff @(posedge clock) begin
      if (rst) begin
         count_q <= 32'h0000_0000;
      end else begin
         count_q <= base + {31'h0000_0000, inc};
      end
   end

   assign value = count_q;

endmodule
`default_nettype wire

// ### io_register_bank.sv
// Holding and input register bank of the serial I/O module with watchdog and reply timing
`timescale 1ns/1ns
`default_nettype none
module io_register_bank #(
   parameter int unsigned MS_CYCLES = io_map_pkg::MS_CYCLES, // Clock cycles per millisecond
   parameter int unsigned DIG_INS = 2, // Digital input pins
   parameter int unsigned DIG_OUTS = 2, // Digital output pins
   parameter logic [15:0] IDENTITY = 16'h0a51 // Arbitrary version and type code
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register access from the protocol engine
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [io_map_pkg::ADDR_W-1:0] regAddr,
   input wire logic [io_map_pkg::DATA_W-1:0] regWdata,
   output logic [io_map_pkg::DATA_W-1:0] regRdata,
   output logic regAck,
   output logic regError,
   // Packet events from the protocol engine
   input wire logic rxPacket,
   input wire logic rxBad,
   input wire logic txPacket,
   input wire logic validMsg,
   // Reply timing
   input wire logic replyReq,
   output logic replyGo,
   output logic replyBusy,
   // Line settings for the framer
   output logic [15:0] lineSpeed,
   output logic [15:0] frameFormat,
   output logic [15:0] paritySelect,
   output logic protocolAscii,
   // Module pins
   input wire logic [7:0] nodeAddrStrap,
   input wire logic [DIG_INS-1:0] digIn,
   output logic [DIG_OUTS-1:0] digOut,
   input wire logic currentRange4to20,
   output logic [15:0] currentSetpoint,
   output logic [15:0] voltageSetpoint,
   output logic watchdogTripped
);
   import io_map_pkg::*;

   // Configuration registers
   logic [15:0] lineSpeed_q;
   logic [15:0] frameFormat_q;
   logic [15:0] parity_q;
   logic [15:0] replyDelay_q;
   logic [15:0] protocolMode_q;
   logic [15:0] linkTimeout_q;
   logic [15:0] safePattern_q;
   // Process data registers
   logic [15:0] outputs_q;
   logic [15:0] current_q;
   logic [15:0] voltage_q;
   // Strapped node address, caught once after reset
   logic [7:0] nodeAddr_q;
   logic strapped_q;
   // Bus answer registers
   logic [15:0] rdata_q;
   logic ack_q;
   logic err_q;
   logic tripped_q;
   // Decode results
   logic known; // Address is mapped
   logic readOnly; // Address is an input register
   logic overRange; // Setpoint above its limit
   logic wrOk; // Write that takes effect
   logic [15:0] readData;
   logic [15:0] currentMax;
   // Time base and timers
   logic [31:0] msDiv_q;
   logic msTick;
   logic wdExpired;
   logic wdBusy;
   logic wdStart;
   logic wdStop;
   logic [15:0] wdLimit; // Timeout in force from this edge on
   logic dlyExpired;
   logic dlyBusy;
   reply_state_type replyState_q;
   // Counter values
   logic [31:0] rxCount;
   logic [31:0] badCount;
   logic [31:0] txCount;

   // Millisecond tick divider
   always_ff @(posedge clock) begin
      if (rst || msTick) begin
         msDiv_q <= 32'h0000_0000;
      end else begin
         msDiv_q <= msDiv_q + 32'h0000_0001;
      end
   end
   assign msTick = (msDiv_q == 32'(MS_CYCLES - 1));

   // Catch the address strap once, after reset has been released
   always_ff @(posedge clock) begin
      if (rst) begin
         nodeAddr_q <= 8'h00;
         strapped_q <= 1'b0;
      end else if (!strapped_q) begin
         nodeAddr_q <= nodeAddrStrap;
         strapped_q <= 1'b1;
      end
   end

   // Limit on current setpoint follows the selected range
   // (R1) microamp ceiling in 0-20 mA range
   // (R2) per-mille ceiling in 4-20 mA range
   assign currentMax = currentRange4to20 ? CURRENT_MAX_PERMILLE : CURRENT_MAX_UA;

   // Address decode; a refused write changes nothing at all
   always_comb begin
      known = 1'b1;
      readOnly = 1'b0;
      overRange = 1'b0;
      unique case (regAddr)
         // (R14) input registers refuse writes
         OFS_IDENTITY, OFS_NODE_ADDR, OFS_INPUTS: begin
            readOnly = 1'b1;
         end
         OFS_CURRENT: begin
            overRange = regWdata > currentMax;
         end
         // (R3) millivolt ceiling on voltage
         OFS_VOLTAGE: begin
            overRange = regWdata > VOLTAGE_MAX_MV;
         end
         OFS_LINE_SPEED, OFS_FRAME_FORMAT, OFS_PARITY, OFS_REPLY_DELAY, OFS_PROTOCOL_MODE,
         OFS_LINK_TIMEOUT, OFS_SAFE_PATTERN, OFS_OUTPUTS, OFS_RX_LOW, OFS_RX_HIGH,
         OFS_BAD_LOW, OFS_BAD_HIGH, OFS_TX_LOW, OFS_TX_HIGH: begin
            known = 1'b1;
         end
         default: begin
            known = 1'b0;
         end
      endcase
   end
   assign wrOk = regWrite && known && !readOnly && !overRange;

   // Configuration registers
   always_ff @(posedge clock) begin
      if (rst) begin
         lineSpeed_q <= RST_LINE_SPEED;
         frameFormat_q <= RST_FRAME_FORMAT;
         parity_q <= RST_PARITY;
         replyDelay_q <= RST_REPLY_DELAY;
         protocolMode_q <= RST_PROTOCOL_MODE;
         linkTimeout_q <= RST_LINK_TIMEOUT;
         safePattern_q <= RST_SAFE_PATTERN;
      end else if (wrOk) begin
         unique case (regAddr)
            OFS_LINE_SPEED: lineSpeed_q <= regWdata;
            OFS_FRAME_FORMAT: frameFormat_q <= regWdata;
            OFS_PARITY: parity_q <= regWdata;
            OFS_REPLY_DELAY: replyDelay_q <= regWdata;
            OFS_PROTOCOL_MODE: protocolMode_q <= regWdata;
            OFS_LINK_TIMEOUT: linkTimeout_q <= regWdata;
            OFS_SAFE_PATTERN: safePattern_q <= regWdata;
            default: begin
            end
         endcase
      end
   end

   // Process outputs; a watchdog trip overrides a write in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         // (R4) safe pattern from power-up
         outputs_q <= RST_SAFE_PATTERN;
         current_q <= RST_SETPOINT;
         voltage_q <= RST_SETPOINT;
      end else if (wdExpired) begin
         // (R10) timeout forces defaults
         outputs_q <= safePattern_q;
         current_q <= RST_SETPOINT;
         voltage_q <= RST_SETPOINT;
      end else if (wrOk) begin
         if (regAddr == OFS_OUTPUTS) begin
            outputs_q <= regWdata;
         end
         if (regAddr == OFS_CURRENT) begin
            current_q <= regWdata;
         end
         if (regAddr == OFS_VOLTAGE) begin
            voltage_q <= regWdata;
         end
      end
   end

   // (R5) three packet statistics counters
   stat_counter rxCounter (
      .clock(clock),
      .rst(rst),
      .inc(rxPacket),
      .wrLow(wrOk && (regAddr == OFS_RX_LOW)),
      .wrHigh(wrOk && (regAddr == OFS_RX_HIGH)),
      .wdata(regWdata),
      .value(rxCount)
   );
   // (R6) erroneous packets counted separately
   stat_counter badCounter (
      .clock(clock),
      .rst(rst),
      .inc(rxBad),
      .wrLow(wrOk && (regAddr == OFS_BAD_LOW)),
      .wrHigh(wrOk && (regAddr == OFS_BAD_HIGH)),
      .wdata(regWdata),
      .value(badCount)
   );
   stat_counter txCounter (
      .clock(clock),
      .rst(rst),
      .inc(txPacket),
      .wrLow(wrOk && (regAddr == OFS_TX_LOW)),
      .wrHigh(wrOk && (regAddr == OFS_TX_HIGH)),
      .wdata(regWdata),
      .value(txCount)
   );

   // Read multiplexer; every register is one 16-bit word
   // (R12) 16-bit register words
   always_comb begin
      readData = 16'h0000;
      unique case (regAddr)
         // (R7) identity at offset zero
         OFS_IDENTITY: readData = IDENTITY;
         OFS_NODE_ADDR: readData = {8'h00, nodeAddr_q};
         OFS_LINE_SPEED: readData = lineSpeed_q;
         OFS_FRAME_FORMAT: readData = frameFormat_q;
         OFS_PARITY: readData = parity_q;
         OFS_REPLY_DELAY: readData = replyDelay_q;
         OFS_PROTOCOL_MODE: readData = protocolMode_q;
         OFS_LINK_TIMEOUT: readData = linkTimeout_q;
         OFS_SAFE_PATTERN: readData = safePattern_q;
         // (R13) low then high word
         OFS_RX_LOW: readData = rxCount[15:0];
         OFS_RX_HIGH: readData = rxCount[31:16];
         OFS_BAD_LOW: readData = badCount[15:0];
         OFS_BAD_HIGH: readData = badCount[31:16];
         OFS_TX_LOW: readData = txCount[15:0];
         OFS_TX_HIGH: readData = txCount[31:16];
         OFS_INPUTS: readData = 16'(digIn);
         OFS_OUTPUTS: readData = outputs_q;
         OFS_CURRENT: readData = current_q;
         OFS_VOLTAGE: readData = voltage_q;
         default: readData = 16'h0000;
      endcase
   end

   // Answer one cycle after each access; read data holds until the next read
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_q <= 16'h0000;
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         ack_q <= regRead || regWrite;
         err_q <= (regRead && !known) || (regWrite && !wrOk);
         if (regRead) begin
            rdata_q <= readData;
         end
      end
   end

   // Watchdog: restarted by each valid message or a new timeout value
   // A timeout written now is loaded at once, as the register itself only takes it at this edge
   assign wdLimit = (wrOk && (regAddr == OFS_LINK_TIMEOUT)) ? regWdata : linkTimeout_q;
   // (R10) zero timeout disables
   assign wdStop = (wdLimit == 16'h0000);
   assign wdStart = validMsg || (wrOk && (regAddr == OFS_LINK_TIMEOUT));
   ms_timer watchdog (
      .clock(clock),
      .rst(rst),
      .start(wdStart),
      .stop(wdStop),
      .msTick(msTick),
      .limit(wdLimit),
      .expired(wdExpired),
      .busy(wdBusy)
   );

   // Sticky trip indication, cleared by the next valid message; a trip in the same cycle wins
   always_ff @(posedge clock) begin
      if (rst) begin
         tripped_q <= 1'b0;
      end else if (wdExpired) begin
         tripped_q <= 1'b1;
      end else if (validMsg) begin
         tripped_q <= 1'b0;
      end
   end

   // (R9) reply held back by reply delay
   ms_timer replyTimer (
      .clock(clock),
      .rst(rst),
      .start(replyReq && (replyState_q == REPLY_IDLE)),
      .stop(1'b0),
      .msTick(msTick),
      .limit(replyDelay_q),
      .expired(dlyExpired),
      .busy(dlyBusy)
   );

   // Reply sequencing; a request while waiting is ignored
   always_ff @(posedge clock) begin
      if (rst) begin
         replyState_q <= REPLY_IDLE;
      end else begin
         unique case (replyState_q)
            REPLY_IDLE: begin
               if (replyReq) begin
                  replyState_q <= REPLY_WAIT;
               end
            end
            REPLY_WAIT: begin
               if (dlyExpired) begin
                  replyState_q <= REPLY_IDLE;
               end
            end
         endcase
      end
   end

   // Outputs
   assign replyGo = dlyExpired && (replyState_q == REPLY_WAIT);
   assign replyBusy = (replyState_q == REPLY_WAIT);
   assign regRdata = rdata_q;
   assign regAck = ack_q;
   assign regError = err_q;
   assign lineSpeed = lineSpeed_q;
   assign frameFormat = frameFormat_q;
   assign paritySelect = parity_q;
   // (R8) framing from protocol mode
   // (R11) value one means ASCII
   assign protocolAscii = (protocolMode_q == 16'h0001);
   assign digOut = outputs_q[DIG_OUTS-1:0];
   assign currentSetpoint = current_q;
   assign voltageSetpoint = voltage_q;
   assign watchdogTripped = tripped_q;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_reply_zero_delay;
      replyReq && replyState_q == REPLY_IDLE && replyDelay_q == 16'h0000;
   endsequence
   sequence s_reply_done;
      ##1 replyGo ##1 !replyBusy;
   endsequence

   a_current_ua_max: assert property ( // (R1)
      regWrite && regAddr == OFS_CURRENT && !currentRange4to20 && regWdata > CURRENT_MAX_UA
      |=> current_q == $past(current_q) || $past(wdExpired))
      else $error("current setpoint took a value above 20480");
   a_current_pm_max: assert property ( // (R2)
      regWrite && regAddr == OFS_CURRENT && currentRange4to20 && regWdata > CURRENT_MAX_PERMILLE
      |=> current_q == $past(current_q) && regError || $past(wdExpired))
      else $error("current setpoint took a value above 1000");
   a_voltage_mv_max: assert property ( // (R3)
      regWrite && regAddr == OFS_VOLTAGE && regWdata <= VOLTAGE_MAX_MV && !wdExpired
      |=> voltage_q == $past(regWdata) && !regError)
      else $error("voltage setpoint lost an in-range write");
   a_safe_on_trip: assert property ( // (R4)
      wdExpired |=> outputs_q == $past(safePattern_q) && current_q == 16'h0000 && watchdogTripped)
      else $error("outputs missed safe pattern after timeout");
   a_rx_count_step: assert property ( // (R5)
      rxPacket && !(regWrite && regAddr[15:1] == OFS_RX_LOW[15:1])
      |=> rxCount == $past(rxCount) + 32'h0000_0001)
      else $error("received counter did not advance");
   a_bad_count_step: assert property ( // (R6)
      rxBad && !rxPacket && !(regWrite && regAddr[15:1] == OFS_BAD_LOW[15:1])
      |=> badCount == $past(badCount) + 32'h0000_0001 && rxCount == $past(rxCount))
      else $error("erroneous counter not independent");
   a_identity_read: assert property ( // (R7)
      regRead && regAddr == OFS_IDENTITY |=> regAck && regRdata == IDENTITY && !regError)
      else $error("identity read returned wrong data");
   a_ascii_select: assert property ( // (R8)
      wrOk && regAddr == OFS_PROTOCOL_MODE |=> protocolAscii == ($past(regWdata) == 16'h0001))
      else $error("framing select did not follow mode write");
   a_reply_zero: assert property ( // (R9)
      s_reply_zero_delay |-> s_reply_done)
      else $error("reply with zero delay not released next cycle");
   a_reply_wait: assert property ( // (R9)
      replyReq && replyState_q == REPLY_IDLE && replyDelay_q != 16'h0000
      |=> !replyGo ##1 (!replyGo || $past(replyDelay_q, 2) == 16'h0001))
      else $error("reply released before its delay");
   a_watchdog_off: assert property ( // (R10)
      linkTimeout_q == 16'h0000 && !(wrOk && regAddr == OFS_LINK_TIMEOUT) |=> !wdExpired && !wdBusy)
      else $error("watchdog ran while disabled");
   a_mode_rtu: assert property ( // (R11)
      protocolMode_q == 16'h0000 |-> !protocolAscii)
      else $error("mode zero did not select RTU");
   a_high_word: assert property ( // (R13)
      regRead && regAddr == OFS_TX_HIGH |=> regRdata == $past(txCount[31:16]))
      else $error("high word read wrong half");
   a_ro_ignored: assert property ( // (R14)
      regWrite && regAddr == OFS_NODE_ADDR && strapped_q |=> $stable(nodeAddr_q) && regError)
      else $error("read-only register changed or write accepted");

endmodule
`default_nettype wire

// ### bus_master_model.sv
// Protocol engine model that issues register strobes to the bank
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
   // Clock
   input wire logic clock,
   // Register strobes
   output logic regWrite,
   output logic regRead,
   output logic [15:0] regAddr,
   output logic [15:0] regWdata
);
   // Idle bus from time zero
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 16'h0000;
      regWdata = 16'h0000;
   end
   // whole 16-bit words
   // One access: strobe for one edge, then idle data shows the inverse so stale values never match
   task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      regWrite <= w;
      regRead <= !w;
      regAddr <= a;
      regWdata <= d;
      @(posedge clock);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      regWdata <= ~d;
      #1;
   endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the serial I/O register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import io_map_pkg::*;
   localparam int unsigned MSC = 10; // Short millisecond keeps the run brief
   localparam logic [15:0] ID = 16'h5a3c; // Arbitrary identity value
   localparam logic [15:0] RWA [6] = '{OFS_LINE_SPEED, OFS_FRAME_FORMAT, OFS_PARITY, OFS_REPLY_DELAY,
                                      OFS_PROTOCOL_MODE, OFS_SAFE_PATTERN};
   localparam logic [15:0] RWV [6] = '{16'h0003, 16'h0108, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic regWrite, regRead, regAck, regError, replyGo, replyBusy, protocolAscii, watchdogTripped;
   logic [15:0] regAddr, regWdata, regRdata, lineSpeed, frameFormat, paritySelect;
   logic [15:0] currentSetpoint, voltageSetpoint, v, b, rxh;
   logic currentRange4to20 = 1'b0;
   logic [7:0] nodeAddrStrap = 8'h00;
   logic [1:0] digIn = 2'h0;
   logic [1:0] digOut;
   logic [4:0] evt = 5'h00; // Event pulses: reply, valid, tx, bad, rx
   logic [17:0] notes[$]; // Expected answers: check-data flag, error, data
   logic [17:0] note;
   int n_fail = 0;
   int n_tests = 0;
   int i;
   int cnt;
   // Free-running clock
   always #4 clock = ~clock;
   bus_master_model master (.clock, .regWrite, .regRead, .regAddr, .regWdata);
   io_register_bank #(.MS_CYCLES(MSC), .DIG_INS(2), .DIG_OUTS(2), .IDENTITY(ID)) dut (
      .clock, .rst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .regAck, .regError,
      .rxPacket(evt[0]), .rxBad(evt[1]), .txPacket(evt[2]), .validMsg(evt[3]), .replyReq(evt[4]),
      .replyGo, .replyBusy, .lineSpeed, .frameFormat, .paritySelect, .protocolAscii, .nodeAddrStrap,
      .digIn, .digOut, .currentRange4to20, .currentSetpoint, .voltageSetpoint, .watchdogTripped);
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Closing report
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Accesses note their expected answer first
   task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic err);
      notes.push_back({1'b1, err, e});
      master.access(1'b0, a, 16'h0000);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic err);
      notes.push_back({1'b0, err, 16'h0000});
      master.access(1'b1, a, d);
   endtask
   // One-cycle event pulse
   task automatic pulse(input logic [4:0] bits);
      @(posedge clock);
      evt <= bits;
      @(posedge clock);
      evt <= 5'h00;
      #1;
   endtask
   // Setpoint limit: the limit is taken, one above is refused
   task automatic sp(input logic r, input logic [15:0] a, input logic [15:0] lim);
      @(posedge clock);
      currentRange4to20 <= r;
      wr(a, lim, 1'b0);
      wr(a, lim + 16'h0001, 1'b1);
      rd(a, lim, 1'b0);
      check((a == OFS_CURRENT) ? currentSetpoint : voltageSetpoint, lim);
   endtask
   // Answer watcher: the oldest note meets each acknowledge
   always @(posedge clock) begin
      if (regAck === 1'b1) begin
         if (notes.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            note = notes.pop_front();
            check({15'h0, regError, note[17] ? regRdata : 16'h0000}, {15'h0, note[16:0]});
         end
      end
   end
   // Main sequence
   initial begin
      void'($urandom(32'h27d1));
      nodeAddrStrap = 8'($urandom());
      digIn = 2'($urandom());
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      check({30'h0, digOut}, 32'h0);
      rd(OFS_IDENTITY, ID, 1'b0);
      rd(OFS_NODE_ADDR, {8'h00, nodeAddrStrap}, 1'b0);
      for (i = 0; i < 6; i++) rd(RWA[i], RWV[i], 1'b0);
      rd(OFS_LINK_TIMEOUT, 16'h0000, 1'b0);
      $display("reset values done");
      // Writable settings read back, read-only and unmapped places refuse
      for (i = 0; i < 4; i++) begin
         v = 16'($urandom());
         wr(RWA[i], v, 1'b0);
         rd(RWA[i], v, 1'b0);
         if (i < 3) check({16'h0, i == 0 ? lineSpeed : (i == 1 ? frameFormat : paritySelect)}, {16'h0, v});
      end
      wr(OFS_LINE_SPEED, 16'h0006, 1'b0);
      wr(OFS_PARITY, 16'h0002, 1'b0);
      check({lineSpeed, paritySelect}, 32'h00060002);
      wr(OFS_REPLY_DELAY, 16'h0000, 1'b0);
      for (i = 0; i < 2; i++) begin
         wr(OFS_PROTOCOL_MODE, 16'(1 - i), 1'b0);
         check({31'h0, protocolAscii}, 32'(1 - i));
      end
      wr(OFS_IDENTITY, 16'($urandom()), 1'b1);
      wr(OFS_NODE_ADDR, 16'($urandom()), 1'b1);
      wr(OFS_INPUTS, 16'($urandom()), 1'b1);
      rd(OFS_IDENTITY, ID, 1'b0);
      rd(OFS_NODE_ADDR, {8'h00, nodeAddrStrap}, 1'b0);
      rd(OFS_INPUTS, {14'h0, digIn}, 1'b0);
      rd(16'h0007, 16'h0000, 1'b1);
      wr(16'h0007, 16'h1234, 1'b1);
      $display("settings done");
      sp(1'b0, OFS_CURRENT, 16'h5000);
      sp(1'b1, OFS_CURRENT, 16'h03e8);
      sp(1'b0, OFS_VOLTAGE, 16'h2800);
      $display("setpoints done");
      // Counters: low word wraps and carries into the high word
      for (i = 0; i < 3; i++) begin
         b = 16'h0020 + 16'(2 * i);
         v = 16'($urandom()) & 16'h7fff;
         if (i == 0) rxh = v + 16'h0001;
         wr(b, 16'hffff, 1'b0);
         wr(b + 16'h0001, v, 1'b0);
         pulse(5'(1 << i));
         rd(b, 16'h0000, 1'b0);
         rd(b + 16'h0001, v + 16'h0001, 1'b0);
      end
      rd(OFS_RX_LOW, 16'h0000, 1'b0);
      rd(OFS_RX_HIGH, rxh, 1'b0);
      $display("counters done");
      // Reply delay measured from the taking edge
      for (i = 0; i < 4; i += 2) begin
         wr(OFS_REPLY_DELAY, 16'(i), 1'b0);
         pulse(5'h10);
         cnt = 1;
         while (replyGo !== 1'b1 && cnt < 100) begin
            @(posedge clock);
            #1;
            cnt++;
         end
         if (cnt >= 100) begin
            n_fail++;
            give_verdict();
         end
         check(cnt >= (i == 0 ? 1 : (i - 1) * MSC + 1) && cnt <= i * MSC + 1, 1);
         @(posedge clock);
         #1;
         check({31'h0, replyBusy}, 32'h0);
      end
      $display("reply delay done");
      // Watchdog trip forces the safe pattern and zero setpoints
      wr(OFS_SAFE_PATTERN, 16'h0001, 1'b0);
      wr(OFS_OUTPUTS, 16'h0003, 1'b0);
      check({30'h0, digOut}, 32'h3);
      wr(OFS_LINK_TIMEOUT, 16'h0002, 1'b0);
      cnt = 0;
      while (watchdogTripped !== 1'b1 && cnt < 40) begin
         @(posedge clock);
         #1;
         cnt++;
      end
      if (cnt >= 40) begin
         n_fail++;
         give_verdict();
      end
      check(cnt >= MSC && cnt <= 2 * MSC + 3, 1);
      check({14'h0, digOut, currentSetpoint}, 32'h0001_0000);
      check({16'h0, voltageSetpoint}, 32'h0000_0000);
      wr(OFS_LINK_TIMEOUT, 16'h0000, 1'b0);
      pulse(5'h08);
      repeat (40) @(posedge clock);
      #1;
      check({31'h0, watchdogTripped}, 32'h0);
      $display("watchdog done");
      repeat (3) @(posedge clock);
      check(notes.size(), 0);
      give_verdict();
   end
endmodule
`default_nettype wire
